// ==== design/switch_power_mgmt_capability.sv ====
`default_nettype none
// Overview of operation
// - Capability ID byte reads 01h.
// - Next pointer resets 5Ch upstream, 4Ch downstream; read-only.
// - Revision field reads 011b.
// - PME clock, B2/B3 and bus power bits hardwired zero.
// - Device specific init reads 0, loadable by management port.
// - AUX current resets 111b, loadable only by management port.
// - D1 and D2 support read 1, loadable by management port.
// - PME support resets 11111b, loadable by management port.
// - Power state 00 D0 to 11 D3hot, resets D0.
// - D3hot to D0 write gives hot reset, no downstream reset.
// - Keep-state bit resets 1; set skips internal reset.
// - PME enable sticky, resets 0; drives event message enable.
// - PME status always reads 0.
// - Data byte resets 00h, loadable by management port.
module switch_power_mgmt_capability
	import pm_cap_pkg::*;
#(
	parameter bit UPSTREAM = 1'b1
)
(
	input  wire logic                      clk,         // Core clock
	input  wire logic                      resetn,      // Async reset
	input  wire logic                      stickyResetn, // Sticky reset
	input  wire logic [pm_cap_pkg::ADDR_W-1:0] addr,    // Config address
	input  wire logic [31:0]               wdata,       // Write data
	input  wire logic                      wr,          // Write strobe
	input  wire logic                      rd,          // Read strobe
	output var  logic [31:0]               rdata,       // Read data
	input  wire logic                      ldStrobe,    // Default load
	input  wire logic [15:0]               ldCap,       // Hdr bits 31:16
	input  wire logic                      ldNoSoft,    // Keep-state
	input  wire logic [7:0]                ldData,      // Data byte
	output var  logic [1:0]                powerState,  // Current state
	output var  logic                      pmeMsgEn,    // Event msg enable
	output var  logic                      hotReset,    // Internal reset
	output var  logic                      downstream_port_reset_n // Held
);
	import pm_cap_pkg::*;

	//////////////////////////////////////////////////////////////////////
	logic       dsi_ff,    nxt_dsi;
	logic [2:0] aux_ff,    nxt_aux;
	logic       d1_ff,     nxt_d1;
	logic       d2_ff,     nxt_d2;
	logic [4:0] pmeSup_ff, nxt_pmeSup;
	logic       noSoft_ff, nxt_noSoft;
	logic [7:0] data_ff,   nxt_data;

	always_comb
	begin
		nxt_dsi    = dsi_ff;
		nxt_aux    = aux_ff;
		nxt_d1     = d1_ff;
		nxt_d2     = d2_ff;
		nxt_pmeSup = pmeSup_ff;
		nxt_noSoft = noSoft_ff;
		nxt_data   = data_ff;
		if (ldStrobe)
		begin
			nxt_dsi    = ldCap[POS_DSI-16];
			nxt_aux    = ldCap[POS_AUX-16 +: 3];
			nxt_d1     = ldCap[POS_D1-16];
			nxt_d2     = ldCap[POS_D2-16];
			nxt_pmeSup = ldCap[POS_PMESUP-16 +: 5];
			nxt_noSoft = ldNoSoft;
			nxt_data   = ldData;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dsi_ff    <= 1'b0;
			aux_ff    <= AUX_RST;
			d1_ff     <= 1'b1;
			d2_ff     <= 1'b1;
			pmeSup_ff <= PME_SUP_RST;
			noSoft_ff <= 1'b1;
			data_ff   <= DATA_RST;
		end
		else
		begin
			dsi_ff    <= nxt_dsi;
			aux_ff    <= nxt_aux;
			d1_ff     <= nxt_d1;
			d2_ff     <= nxt_d2;
			pmeSup_ff <= nxt_pmeSup;
			noSoft_ff <= nxt_noSoft;
			data_ff   <= nxt_data;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Software state
	pstate_t    ps_ff,   nxt_ps;
	logic [3:0] dsel_ff, nxt_dsel;
	logic       pmeEn_ff, nxt_pmeEn;
	logic       wrCtrl;
	logic       leaveD3;
	logic       intRst;

	assign wrCtrl = wr && (addr == OFS_CTRL);

	always_comb
	begin
		nxt_ps   = ps_ff;
		nxt_dsel = dsel_ff;
		leaveD3  = 1'b0;
		if (wrCtrl)
		begin
			nxt_ps   = pstate_t'(wdata[1:0]);
			nxt_dsel = wdata[POS_DSEL +: 4];
			leaveD3  = (ps_ff == PS_D3HOT) &&
				(pstate_t'(wdata[1:0]) == PS_D0);
		end
		if (intRst)
		begin
			nxt_ps   = PS_D0;
			nxt_dsel = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ps_ff   <= PS_D0;
			dsel_ff <= 4'h0;
		end
		else
		begin
			ps_ff   <= nxt_ps;
			dsel_ff <= nxt_dsel;
		end
	end

	// Sticky: survives ordinary and hot reset
	always_comb
	begin
		nxt_pmeEn = pmeEn_ff;
		if (wrCtrl)
			nxt_pmeEn = wdata[POS_PMEEN];
	end

	always_ff @(posedge clk or negedge stickyResetn)
	begin
		if (!stickyResetn)
			pmeEn_ff <= 1'b0;
		else
			pmeEn_ff <= nxt_pmeEn;
	end

	//////////////////////////////////////////////////////////////////////
	// Hot reset on D3hot to D0 unless keep-state is set
	logic rstStart;
	assign rstStart = leaveD3 && !noSoft_ff;

	pm_hot_reset #(.LEN(HOTRST_CYC)) u_hot
	(
		.clk    (clk),
		.resetn (resetn),
		.start  (rstStart),
		.busy   (intRst)
	);

	//////////////////////////////////////////////////////////////////////
	// Read mux
	logic [31:0] hdrWord, ctrlWord, nxt_rdata;

	always_comb
	begin
		hdrWord                      = 32'h0000_0000;
		hdrWord[7:0]                 = CAP_ID;
		hdrWord[15:8]                = UPSTREAM ? NEXT_UP
			: NEXT_DOWN;
		hdrWord[POS_REV +: 3]        = PM_REV;
		hdrWord[POS_PMECLK]          = 1'b0;
		hdrWord[POS_DSI]             = dsi_ff;
		hdrWord[POS_AUX +: 3]        = aux_ff;
		hdrWord[POS_D1]              = d1_ff;
		hdrWord[POS_D2]              = d2_ff;
		hdrWord[POS_PMESUP +: 5]     = pmeSup_ff;
		ctrlWord                     = 32'h0000_0000;
		ctrlWord[1:0]                = ps_ff;
		ctrlWord[POS_NOSOFT]         = noSoft_ff;
		ctrlWord[POS_PMEEN]          = pmeEn_ff;
		ctrlWord[POS_DSEL +: 4]      = dsel_ff;
		ctrlWord[POS_DSCALE +: 2]    = 2'b00;
		ctrlWord[POS_PMESTAT]        = 1'b0;
		ctrlWord[23:22]              = 2'b00;
		ctrlWord[POS_DATA +: 8]      = data_ff;
		nxt_rdata = 32'h0000_0000;
		if (rd)
		begin
			unique case (addr)
				OFS_HEADER: nxt_rdata = hdrWord;
				OFS_CTRL:   nxt_rdata = ctrlWord;
				default:    nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata                   <= 32'h0000_0000;
			powerState              <= 2'b00;
			pmeMsgEn                <= 1'b0;
			hotReset                <= 1'b0;
			downstream_port_reset_n <= 1'b1;
		end
		else
		begin
			rdata                   <= nxt_rdata;
			powerState              <= nxt_ps;
			pmeMsgEn                <= nxt_pmeEn;
			hotReset                <= intRst;
			downstream_port_reset_n <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_hdr_read;
		rd && addr == OFS_HEADER;
	endsequence

	sequence s_ctrl_read;
		rd && addr == OFS_CTRL;
	endsequence

	sequence s_other_read;
		rd && addr != OFS_HEADER && addr != OFS_CTRL;
	endsequence

	sequence s_leave_d3;
		wrCtrl && ps_ff == PS_D3HOT && wdata[1:0] == 2'b00;
	endsequence

	sequence s_load_hdr;
		ldStrobe ##1 s_hdr_read;
	endsequence

	sequence s_load_ctrl;
		ldStrobe ##1 s_hdr_read ##1 s_ctrl_read;
	endsequence

	a_cap_id: assert property (
		s_hdr_read |=> rdata[7:0] == 8'h01)
		else $error("capability id wrong");
	a_next_ptr: assert property (
		s_hdr_read |=> rdata[15:8] == (UPSTREAM ? 8'h5C : 8'h4C))
		else $error("next pointer wrong");
	a_rev_const: assert property (
		s_hdr_read |=> rdata[18:16] == 3'b011)
		else $error("revision wrong");
	a_legacy_zero: assert property (
		s_hdr_read |=> !rdata[19] && !rdata[20])
		else $error("legacy bit set");
	a_ext_zero: assert property (
		s_ctrl_read |=> rdata[23:22] == 2'b00)
		else $error("extension bit set");
	a_ctrl_zero: assert property (
		s_ctrl_read |=> !rdata[15] && rdata[14:13] == 2'b00 && !rdata[2])
		else $error("fixed control bits set");
	a_rsvd_zero: assert property (
		s_ctrl_read |=> rdata[7:4] == 4'h0 && rdata[21:16] == 6'h00)
		else $error("reserved control bits set");
	a_unmapped: assert property (
		s_other_read |=> rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ps_write: assert property (
		wrCtrl && !intRst |=> powerState == $past(wdata[1:0]))
		else $error("power state not stored");
	a_dsel_write: assert property (
		wrCtrl && !intRst |=> dsel_ff == $past(wdata[12:9]))
		else $error("data select not stored");
	a_hot_rst: assert property (
		s_leave_d3 ##0 !noSoft_ff |=> ##1 hotReset [*4] ##1 !hotReset)
		else $error("hot reset missing");
	a_hot_clear: assert property (
		intRst |=> powerState == 2'b00 && dsel_ff == 4'h0)
		else $error("hot reset left state");
	a_keep_state: assert property (
		s_leave_d3 ##0 noSoft_ff && !intRst |=> ##1 !hotReset)
		else $error("reset despite keep-state");
	a_no_dwn: assert property (
		downstream_port_reset_n)
		else $error("downstream reset driven");
	a_pme_en: assert property (
		wrCtrl |=> pmeMsgEn == $past(wdata[8]))
		else $error("pme enable not tracked");
	a_load_dsi: assert property (
		s_load_hdr |=> rdata[21] == $past(ldCap[5], 2))
		else $error("init bit load lost");
	a_load_aux: assert property (
		s_load_hdr |=> rdata[24:22] == $past(ldCap[8:6], 2))
		else $error("aux load lost");
	a_load_dx: assert property (
		s_load_hdr |=> rdata[26:25] == $past(ldCap[10:9], 2))
		else $error("d1 d2 load lost");
	a_load_pme: assert property (
		s_load_hdr |=> rdata[31:27] == $past(ldCap[15:11], 2))
		else $error("pme support load lost");
	a_load_keep: assert property (
		s_load_ctrl |=> rdata[3] == $past(ldNoSoft, 3))
		else $error("keep-state load lost");
	a_load_data: assert property (
		s_load_ctrl |=> rdata[31:24] == $past(ldData, 3))
		else $error("data byte load lost");
endmodule
`default_nettype wire

// ==== design/pm_cap_pkg.sv ====
`default_nettype none
package pm_cap_pkg;
	localparam int           ADDR_W        = 8;
	localparam logic [7:0]   OFS_HEADER    = 8'h40;
	localparam logic [7:0]   OFS_CTRL      = 8'h44;
	localparam logic [7:0]   CAP_ID        = 8'h01;
	localparam logic [7:0]   NEXT_UP       = 8'h5C;
	localparam logic [7:0]   NEXT_DOWN     = 8'h4C;
	localparam logic [2:0]   PM_REV        = 3'h3;
	localparam logic [2:0]   AUX_RST       = 3'h7;
	localparam logic [4:0]   PME_SUP_RST   = 5'h1F;
	localparam logic [7:0]   DATA_RST      = 8'h00;
	// Header field positions
	localparam int           POS_REV       = 16;
	localparam int           POS_PMECLK    = 19;
	localparam int           POS_DSI       = 21;
	localparam int           POS_AUX       = 22;
	localparam int           POS_D1        = 25;
	localparam int           POS_D2        = 26;
	localparam int           POS_PMESUP    = 27;
	// Control/status field positions
	localparam int           POS_NOSOFT    = 3;
	localparam int           POS_PMEEN     = 8;
	localparam int           POS_DSEL      = 9;
	localparam int           POS_DSCALE    = 13;
	localparam int           POS_PMESTAT   = 15;
	localparam int           POS_DATA      = 24;
	// Hot reset pulse length in cycles
	localparam int           HOTRST_CYC    = 4;
	typedef enum logic [1:0]
	{
		PS_D0    = 2'b00,
		PS_D1    = 2'b01,
		PS_D2    = 2'b10,
		PS_D3HOT = 2'b11
	} pstate_t;
endpackage
`default_nettype wire

// ==== design/pm_hot_reset.sv ====
`default_nettype none
module pm_hot_reset
	import pm_cap_pkg::*;
#(
	parameter int LEN = pm_cap_pkg::HOTRST_CYC
)
(
	input  wire logic clk,      // Core clock
	input  wire logic resetn,   // Async reset, active low
	input  wire logic start,    // One-cycle trigger
	output var  logic busy      // Reset pulse, registered
);
	if (LEN < 1 || LEN > 255)
	begin
		$error("LEN out of range");
	end

	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic       nxt_busy;

	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (start)
			nxt_cnt = 8'(LEN);
		else if (cnt_ff != 8'h00)
			nxt_cnt = cnt_ff - 8'h01;
		nxt_busy = (nxt_cnt != 8'h00);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= 8'h00;
			busy   <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			busy   <= nxt_busy;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pm_cap_pkg::*;

	localparam logic [31:0] HDR_UP = {PME_SUP_RST, 2'b11, AUX_RST, 3'b000,
		PM_REV, NEXT_UP, CAP_ID};
	localparam logic [31:0] HDR_DN = {PME_SUP_RST, 2'b11, AUX_RST, 3'b000,
		PM_REV, NEXT_DOWN, CAP_ID};

	logic        clk          = 1'b0;
	logic        resetn       = 1'b0;
	logic        stickyResetn = 1'b0;
	logic        wr           = 1'b0;
	logic        rd           = 1'b0;
	logic        ldStrobe     = 1'b0;
	logic        ldNoSoft     = 1'b1;
	logic [7:0]  addr         = 8'h00;
	logic [7:0]  ldData       = 8'h00;
	logic [15:0] ldCap        = 16'hFFFF;
	logic [31:0] wdata        = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] rdataDn;
	logic [31:0] v;
	logic [31:0] vd;
	logic [1:0]  powerState;
	logic        pmeMsgEn;
	logic        hotReset;
	logic        dsRstN;
	int          failCount    = 0;
	int          testsRun     = 0;
	int          n;

	always #4 clk = ~clk;

	switch_power_mgmt_capability #(.UPSTREAM(1'b1)) u_dut (
		.clk(clk), .resetn(resetn), .stickyResetn(stickyResetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ldStrobe(ldStrobe), .ldCap(ldCap), .ldNoSoft(ldNoSoft),
		.ldData(ldData), .powerState(powerState), .pmeMsgEn(pmeMsgEn),
		.hotReset(hotReset), .downstream_port_reset_n(dsRstN));

	switch_power_mgmt_capability #(.UPSTREAM(1'b0)) u_down (
		.clk(clk), .resetn(resetn), .stickyResetn(stickyResetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdataDn),
		.ldStrobe(ldStrobe), .ldCap(ldCap), .ldNoSoft(ldNoSoft),
		.ldData(ldData), .powerState(), .pmeMsgEn(), .hotReset(),
		.downstream_port_reset_n());

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			failCount++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd32(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		vd = rdataDn;
	endtask

	// Counts hot reset cycles, port reset must stay released
	task automatic hotCount(output int c);
		c = 0;
		repeat (10)
		begin
			@(posedge clk);
			#1;
			if (hotReset === 1'b1)
				c++;
			check({31'h0, dsRstN}, 32'h1);
		end
	endtask

	task automatic printVerdict;
		if (failCount == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#50000;
		failCount++;
		printVerdict();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		stickyResetn <= 1'b1;
		rd32(OFS_HEADER);
		check(v, HDR_UP);
		check(vd, HDR_DN);
		check({29'h0, hotReset, dsRstN, pmeMsgEn}, 32'h2);
		rd32(OFS_CTRL);
		check(v, 32'h0000_0008);
		wr32(OFS_HEADER, 32'hFFFF_FFFF);
		rd32(OFS_HEADER);
		check(v, HDR_UP);
		rd32(8'h48);
		check(v, 32'h0000_0000);
		wr32(OFS_CTRL, 32'hFFFF_FFFF);
		rd32(OFS_CTRL);
		check(v, 32'h0000_1F0B);
		check({29'h0, pmeMsgEn, powerState}, 32'h7);
		// Keep-state set: leaving D3hot gives no internal reset
		wr32(OFS_CTRL, 32'h0000_1F00);
		hotCount(n);
		check(n, 32'h0);
		for (int s = 0; s < 4; s++)
		begin
			wr32(OFS_CTRL, 32'h0000_1F00 | s);
			rd32(OFS_CTRL);
			check(v, 32'h0000_1F08 | s);
			check({30'h0, powerState}, 32'(s));
		end
		@(posedge clk);
		ldStrobe <= 1'b1;
		ldCap <= 16'h0020;
		ldNoSoft <= 1'b0;
		ldData <= 8'hA5;
		@(posedge clk);
		ldStrobe <= 1'b0;
		rd <= 1'b1;
		addr <= OFS_HEADER;
		@(posedge clk);
		addr <= OFS_CTRL;
		#1;
		v = rdata;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		vd = rdata;
		check(v, {16'h0023, NEXT_UP, CAP_ID});
		check(vd, 32'hA500_1F03);
		// Keep-state clear: D3hot to D0 runs the internal reset
		wr32(OFS_CTRL, 32'h0000_1F00);
		hotCount(n);
		check(n, 32'(HOTRST_CYC));
		rd32(OFS_CTRL);
		check(v, 32'hA500_0100);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd32(OFS_CTRL);
		check(v, 32'h0000_0108);
		check({31'h0, pmeMsgEn}, 32'h1);
		@(posedge clk);
		stickyResetn <= 1'b0;
		repeat (2) @(posedge clk);
		stickyResetn <= 1'b1;
		rd32(OFS_CTRL);
		check(v, 32'h0000_0008);
		check({31'h0, pmeMsgEn}, 32'h0);
		printVerdict();
	end
endmodule
`default_nettype wire
